// file: verilog/cycle_timing_pkg.sv
/*
 * Shared constants and types of the tester cycle and phase timing block.
 * Assumes a single 40 MHz reference clock; one fast tick stands for 8 ns.
 */
package cycle_timing_pkg;
    // ==========================================================
    // Sizes
    localparam int PINS = 64;
    localparam int PHASES = 14;
    localparam int GROUPS = 4;
    localparam int GROUP_PINS = 16;
    localparam int CYC_W = 21;
    localparam int CNT_W = 11;
    localparam int PH_W = 16;
    // ==========================================================
    // Times in ns
    localparam int MIN_CYCLE_NS = 48;
    localparam int FAST_MAX_NS = 16376;
    localparam int MAX_CYCLE_NS = 1048000;
    localparam int FAST_RES_NS = 8;
    localparam int SLOW_RES_NS = 512;
    localparam int MIN_CLK_NS = 48;
    // Derived counts
    localparam int FAST_SHIFT = $clog2(FAST_RES_NS);
    localparam int SLOW_SHIFT = $clog2(SLOW_RES_NS);
    localparam int SLOW_DIV = SLOW_RES_NS / FAST_RES_NS;
    localparam logic [CNT_W-1:0] MIN_CLK_TICKS =
        CNT_W'(MIN_CLK_NS / FAST_RES_NS);
    localparam logic [3:0] NO_PHASE = 4'hF;
    localparam logic [63:0] PIN_RESET = 64'h0;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        cfg_8f6c, cfg_10f4c, cfg_12f2c, cfg_5f2c
    } phase_cfg_e;
    typedef enum logic [1:0] {
        non_return_timing, return_to_zero_timing, complement_return_timing
    } force_timing_e;
    typedef enum logic {range_fast, range_slow} range_e;
    typedef struct packed {
        logic [CYC_W-1:0] ns;
        logic ext_sync;
    } cycle_cmd_s;
    typedef struct packed {
        logic [PH_W-1:0] start;
        logic [PH_W-1:0] width;
    } phase_prog_s;
    typedef struct packed {
        logic [3:0] init_force;
        logic [3:0] prog_force;
        logic [3:0] init_compare;
        logic [3:0] prog_compare;
    } pin_phases_s;
endpackage : cycle_timing_pkg

// file: verilog/tester_cycle_phase_timing.sv
/*
 * Cycle reference, shift-clock pulses, phase generators, per-pin phase
 * distribution and force data timing of a logic tester station.
 * Assumes all command inputs except start_button and ext_sync_in come
 * from logic on ref_clk; those two are pins and are synchronised here.
 */
// Operation
// RULE1: each pin gets two force phases and two compare phases; pin_map gives some pins no initial force phase (NO_PHASE)
// RULE2: at test start every pin uses its initial phase pair
// RULE3: program-phase command routes program force and compare phases
// RULE4: initialise, start button or restore command select initial phases
// RULE5: four distribution configurations decide force or compare use
// RULE6: 8/6 map: program force, initial compare, program compare, init force
// RULE7: last compare phase is 6, 10, 9 or 6 per configuration
// RULE8: cycle-start mark repeats every programmed tested-part cycle
// RULE9: external sync option locks the cycle timing to an input
// RULE10: shift registers get one pulse per clock cycle, 1, 2 or 4
// RULE11: pulse mode follows sector mode: 1, 2 for 2 and 3, 4
// RULE12: shortest clock cycle is 48 ns
// RULE13: cycle spans 48 ns to 1.048 ms in fast and slow ranges
// RULE14: fast range mode 1 truncates to a multiple of 8 ns
// RULE15: slow range mode 1 rounds to nearest multiple of 512 ns
// RULE16: resolution scales with pulse mode in both ranges
// RULE17: programmer avoids modes whose pulses do not fit the cycle
// RULE18: force timing is non-return, return-to-zero or complement per group
// RULE19: non-return mode holds the level all cycle, changing at the mark
// RULE20: return-to-zero drives data only during the force phase pulse
// RULE21: force phase placed from the mark, may span or skip cycles
// RULE22: without return-to-zero request a group uses non-return timing
// RULE23: fourteen or seven independently positioned phases
// RULE24: cycle below 48 ns or above 1.048 ms is flagged and halts
// RULE25: complement mode drives inverse outside the force pulse, true inside
// RULE26: mark from period counter at range resolution, reloaded each end
`timescale 1ns/1ps
`default_nettype none
module tester_cycle_phase_timing
    import cycle_timing_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire cycle_cmd_s cycle_cmd,
    input wire logic cycle_load,
    input wire logic [1:0] sector_mode,
    input wire phase_cfg_e phase_cfg,
    input wire phase_prog_s phase_prog [PHASES],
    input wire force_timing_e group_timing [GROUPS],
    input wire logic [PINS-1:0] force_data,
    input wire logic [PINS-1:0] pin_mask,
    input wire logic select_program_phases,
    input wire logic restore_initial_phases,
    input wire logic initialise_command,
    input wire logic start_button,
    input wire logic ext_sync_in,
    output logic cycle_start_mark_r,
    output logic shift_clock_r,
    output logic [PHASES-1:0] phase_out_r,
    output logic [PHASES-1:0] phase_is_force_r,
    output logic [3:0] last_compare_r,
    output logic [PINS-1:0] force_drive_r,
    output logic [PINS-1:0] compare_strobe_r,
    output logic [PINS-1:0] program_sel_r,
    output logic [2:0] pulse_mode_r,
    output logic active_range_r,
    output logic cycle_error_r,
    output logic test_halted_r
);
    // ==========================================================
    // Decoding functions
    function automatic logic [1:0] mode_shift(input logic [1:0] sm);
        unique case (sm)
            2'h0: mode_shift = 2'h0;
            2'h1, 2'h2: mode_shift = 2'h1;
            default: mode_shift = 2'h2;
        endcase
    endfunction : mode_shift

    function automatic pin_phases_s pin_map(input phase_cfg_e c,
                                            input logic [5:0] p);
        pin_phases_s m;
        m = '{NO_PHASE, NO_PHASE, NO_PHASE, NO_PHASE};
        unique case (c)
            cfg_8f6c: begin
                m.prog_force = {2'h0, p[5:4]};
                m.init_compare = 4'h4 + {3'h0, p[5]};
                m.prog_compare = 4'h6 + {2'h0, p[5:4]};
                if (p[5:4] != 2'h3) m.init_force = 4'hA + {2'h0, p[5:4]};
            end
            cfg_10f4c: begin
                m.prog_force = {1'h0, p[5:3]};
                m.init_compare = 4'h8 + {3'h0, p[5]};
                m.prog_compare = 4'hA + {3'h0, p[5]};
                if (!p[5]) m.init_force = 4'hC;
            end
            cfg_12f2c: begin
                m.prog_force = {1'h0, p[5:3]};
                m.prog_compare = 4'h8;
                m.init_compare = 4'h9;
                if (p[5:4] != 2'h3) m.init_force = 4'hA + {2'h0, p[5:4]};
            end
            cfg_5f2c: begin
                m.prog_force = {2'h0, p[5:4]};
                m.prog_compare = 4'h4;
                m.init_compare = 4'h5;
                m.init_force = 4'h6;
            end
        endcase
        pin_map = m;
    endfunction : pin_map

    function automatic logic pick(input logic [PHASES-1:0] ph,
                                  input logic [3:0] idx);
        pick = (idx < 4'(PHASES)) ? ph[idx] : 1'b0;
    endfunction : pick

    // ==========================================================
    // Pin synchronisers
    logic [1:0] start_sync_r;
    logic [1:0] ext_sync_r;
    logic start_seen_r;
    logic ext_seen_r;
    logic start_rise;
    logic ext_rise;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            start_sync_r <= 2'h0;
            ext_sync_r <= 2'h0;
            start_seen_r <= 1'b0;
            ext_seen_r <= 1'b0;
        end else begin
            start_sync_r <= {start_sync_r[0], start_button};
            ext_sync_r <= {ext_sync_r[0], ext_sync_in};
            start_seen_r <= start_sync_r[1];
            ext_seen_r <= ext_sync_r[1];
        end
    end

    assign start_rise = start_sync_r[1] & ~start_seen_r;
    assign ext_rise = ext_sync_r[1] & ~ext_seen_r;

    // ==========================================================
    // Cycle programming and range check
    logic [1:0] ms;
    logic [CYC_W-1:0] ns;
    logic cyc_bad;
    logic cyc_fast;
    logic [CYC_W-1:0] fast_len;
    logic [CYC_W-1:0] slow_len;
    logic [CNT_W-1:0] ccl_nxt;
    logic [CNT_W-1:0] ccl_r;
    logic [1:0] ms_r;
    logic ext_en_r;
    logic running_r;

    assign ms = mode_shift(sector_mode); // [RULE11]
    assign ns = cycle_cmd.ns;
    assign cyc_fast = ns <= CYC_W'(FAST_MAX_NS); // [RULE13]
    assign fast_len = ns >> (FAST_SHIFT + int'(ms)); // [RULE14] [RULE16]
    assign slow_len = (ns + (CYC_W'(SLOW_RES_NS / 2) << ms))
                      >> (SLOW_SHIFT + int'(ms)); // [RULE15] [RULE16]
    assign ccl_nxt = cyc_fast ? fast_len[CNT_W-1:0] : slow_len[CNT_W-1:0];
    assign cyc_bad = ns < CYC_W'(MIN_CYCLE_NS)
                     || ns > CYC_W'(MAX_CYCLE_NS)
                     || (cyc_fast && ccl_nxt < MIN_CLK_TICKS)
                     || ccl_nxt == '0; // [RULE24] [RULE12]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ccl_r <= MIN_CLK_TICKS;
            ms_r <= 2'h0;
            ext_en_r <= 1'b0;
            active_range_r <= range_fast;
            running_r <= 1'b0;
            cycle_error_r <= 1'b0;
            test_halted_r <= 1'b0;
        end else if (cycle_load) begin
            if (cyc_bad) begin
                running_r <= 1'b0; // [RULE24]
                cycle_error_r <= 1'b1;
                test_halted_r <= 1'b1;
            end else begin
                ccl_r <= ccl_nxt;
                ms_r <= ms;
                ext_en_r <= cycle_cmd.ext_sync;
                active_range_r <= cyc_fast ? range_fast : range_slow;
                running_r <= 1'b1;
                cycle_error_r <= 1'b0;
                test_halted_r <= 1'b0;
            end
        end else if (start_rise) begin
            cycle_error_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) pulse_mode_r <= 3'h1;
        else pulse_mode_r <= 3'h1 << ms; // [RULE11]
    end

    // ==========================================================
    // Resolution tick and period counter
    logic [5:0] div_r;
    logic tick;
    logic [CNT_W-1:0] clk_cnt_r;
    logic [1:0] sub_r;
    logic cnt_end;
    logic mark_now;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) div_r <= 6'h0;
        else if (div_r == 6'(SLOW_DIV - 1) || cycle_load) div_r <= 6'h0;
        else div_r <= div_r + 6'h1;
    end

    assign tick = running_r
                  && (active_range_r == range_fast || div_r == 6'h0);
    assign cnt_end = tick && clk_cnt_r == '0;
    assign mark_now = ext_en_r ? (running_r && ext_rise) // [RULE9]
                             : (cnt_end && sub_r == 2'h0); // [RULE8]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_cnt_r <= '0;
            sub_r <= 2'h0;
            shift_clock_r <= 1'b0;
            cycle_start_mark_r <= 1'b0;
        end else begin
            shift_clock_r <= cnt_end || (ext_en_r && mark_now); // [RULE10]
            cycle_start_mark_r <= mark_now;
            if (cycle_load || !running_r) begin
                clk_cnt_r <= '0;
                sub_r <= 2'h0;
            end else if (ext_en_r && mark_now) begin
                clk_cnt_r <= ccl_r - CNT_W'(1); // [RULE9]
                sub_r <= 2'((3'h1 << ms_r) - 3'h1);
            end else if (cnt_end) begin
                clk_cnt_r <= ccl_r - CNT_W'(1); // [RULE26]
                if (sub_r == 2'h0) begin
                    if (!ext_en_r) sub_r <= 2'((3'h1 << ms_r) - 3'h1);
                end else begin
                    sub_r <= sub_r - 2'h1; // [RULE10]
                end
            end else if (tick) begin
                clk_cnt_r <= clk_cnt_r - CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // Phase generators
    logic [PH_W-1:0] ph_cnt_r [PHASES];
    logic [PHASES-1:0] ph_busy_r;
    logic [PHASES-1:0] ph_live;

    assign ph_live = (phase_cfg == cfg_5f2c) ? 14'h007F : 14'h3FFF; // [RULE23]

    for (genvar i = 0; i < PHASES; i++) begin : g_phase
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                ph_cnt_r[i] <= '0;
                ph_busy_r[i] <= 1'b0;
                phase_out_r[i] <= 1'b0;
            end else if (!running_r || !ph_live[i]) begin
                ph_busy_r[i] <= 1'b0;
                phase_out_r[i] <= 1'b0;
            end else if (!ph_busy_r[i]) begin
                if (mark_now) begin // [RULE21]
                    ph_busy_r[i] <= 1'b1;
                    phase_out_r[i] <= phase_prog[i].start == '0;
                    ph_cnt_r[i] <= (phase_prog[i].start == '0)
                                   ? phase_prog[i].width
                                   : phase_prog[i].start;
                end
            end else if (tick || mark_now) begin
                if (ph_cnt_r[i] <= PH_W'(1)) begin
                    phase_out_r[i] <= !phase_out_r[i];
                    ph_busy_r[i] <= !phase_out_r[i];
                    ph_cnt_r[i] <= phase_prog[i].width;
                end else begin
                    ph_cnt_r[i] <= ph_cnt_r[i] - PH_W'(1);
                end
            end
        end
    end

    // ==========================================================
    // Distribution and per-pin selection
    logic [PINS-1:0] pin_force;
    logic [PINS-1:0] pin_compare;
    logic [PHASES-1:0] force_map;

    always_comb begin
        force_map = '0;
        for (int p = 0; p < PINS; p++) begin
            pin_phases_s m;
            m = pin_map(phase_cfg, 6'(p)); // [RULE5] [RULE6]
            if (m.prog_force != NO_PHASE) force_map[m.prog_force] = 1'b1;
            if (m.init_force != NO_PHASE) force_map[m.init_force] = 1'b1;
            pin_force[p] = program_sel_r[p] // [RULE1]
                ? pick(phase_out_r, m.prog_force)
                : pick(phase_out_r, m.init_force);
            pin_compare[p] = program_sel_r[p]
                ? pick(phase_out_r, m.prog_compare)
                : pick(phase_out_r, m.init_compare);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            program_sel_r <= PIN_RESET; // [RULE2]
        end else if (initialise_command || start_rise) begin
            program_sel_r <= PIN_RESET; // [RULE4]
        end else if (restore_initial_phases) begin
            program_sel_r <= program_sel_r & ~pin_mask; // [RULE4]
        end else if (select_program_phases) begin
            program_sel_r <= program_sel_r | pin_mask; // [RULE3]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_is_force_r <= '0;
            last_compare_r <= 4'h6;
        end else begin
            phase_is_force_r <= force_map & ph_live; // [RULE5]
            unique case (phase_cfg) // [RULE7]
                cfg_10f4c: last_compare_r <= 4'hA;
                cfg_12f2c: last_compare_r <= 4'h9;
                default: last_compare_r <= 4'h6;
            endcase
        end
    end

    // ==========================================================
    // Force data timing
    logic [PINS-1:0] data_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) data_r <= '0;
        else if (mark_now) data_r <= force_data; // [RULE19]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            force_drive_r <= '0;
            compare_strobe_r <= '0;
        end else begin
            compare_strobe_r <= pin_compare;
            for (int p = 0; p < PINS; p++) begin
                unique case (group_timing[p / GROUP_PINS]) // [RULE18]
                    return_to_zero_timing:
                        force_drive_r[p] <= pin_force[p] & data_r[p]; // [RULE20]
                    complement_return_timing:
                        force_drive_r[p] <= pin_force[p] ? data_r[p]
                                                         : ~data_r[p]; // [RULE25]
                    default:
                        force_drive_r[p] <= data_r[p]; // [RULE22]
                endcase
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_steady6;
        running_r && !ext_en_r && !cycle_load && ccl_r == 11'd6
        && ms_r == 2'h0 && active_range_r == range_fast;
    endsequence

    a_mark_period: assert property ( // [RULE8]
        s_steady6 ##1 (cycle_start_mark_r and s_steady6) ##1 s_steady6[*6]
        |-> cycle_start_mark_r && !$past(cycle_start_mark_r, 1)
            && !$past(cycle_start_mark_r, 2) && !$past(cycle_start_mark_r, 3)
            && !$past(cycle_start_mark_r, 4) && !$past(cycle_start_mark_r, 5))
        else $error("cycle start mark period wrong");
    a_range_reject: assert property ( // [RULE24]
        cycle_load && (ns < 21'd48 || ns > 21'd1048000)
        |=> cycle_error_r && test_halted_r && !running_r)
        else $error("out of range cycle accepted");
    a_fast_trunc: assert property ( // [RULE14]
        cycle_load && !cyc_bad && cyc_fast && ms == 2'h0
        |=> ccl_r == 11'($past(ns) >> 3))
        else $error("fast cycle not truncated to 8 ns");
    a_slow_round: assert property ( // [RULE15]
        cycle_load && !cyc_bad && !cyc_fast && ms == 2'h0
        |=> ccl_r == 11'(($past(ns) + 21'd256) >> 9))
        else $error("slow cycle not rounded to 512 ns");
    a_pulse_mode: assert property ( // [RULE11]
        sector_mode == 2'h1 || sector_mode == 2'h2 |=> pulse_mode_r == 3'h2)
        else $error("pulse mode not 2 for sector modes 2 and 3");
    a_init_restore: assert property ( // [RULE4]
        initialise_command || start_rise |=> program_sel_r == '0)
        else $error("initial phases not restored");
    a_prog_select: assert property ( // [RULE3]
        select_program_phases && !restore_initial_phases
        && !initialise_command && !start_rise
        |=> (program_sel_r & $past(pin_mask)) == $past(pin_mask))
        else $error("program phases not selected");
    a_last_compare: assert property ( // [RULE7]
        phase_cfg == cfg_10f4c ##1 phase_cfg == cfg_10f4c
        |-> last_compare_r == 4'hA)
        else $error("last compare phase wrong");
    a_zero_drive: assert property ( // [RULE20]
        group_timing[0] == return_to_zero_timing && !pin_force[0]
        |=> !force_drive_r[0])
        else $error("return to zero drives outside phase");
    a_compl_drive: assert property ( // [RULE25]
        group_timing[1] == complement_return_timing && !pin_force[16]
        |=> force_drive_r[16] == !$past(data_r[16]))
        else $error("complement not driven outside phase");
endmodule : tester_cycle_phase_timing
`default_nettype wire

// file: dv/dut_pin_model.sv
/*
 * Behavioural tested part seen from the pin drivers.
 * Assumes the driver levels are registered on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dut_pin_model
    import cycle_timing_pkg::*;
(
    input wire logic ref_clk,
    input wire logic cycle_start_mark,
    input wire logic [PINS-1:0] force_drive,
    output logic [PINS-1:0] seen_level
);
    logic mark_d;
    // Level taken once the new cycle's data has reached the driver
    always_ff @(posedge ref_clk) begin
        mark_d <= cycle_start_mark;
        if (mark_d) begin
            seen_level <= force_drive;
        end
    end
endmodule : dut_pin_model
`default_nettype wire

// file: dv/test_tester_cycle_phase_timing.sv
/*
 * Self-checking bench of the cycle and phase timing block.
 * Assumes the package of the block and the pin model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_tester_cycle_phase_timing
    import cycle_timing_pkg::*;
;
    logic ref_clk = 0, rst = 1, cycle_load = 0, start_button = 0;
    logic select_program_phases = 0, restore_initial_phases = 0;
    logic initialise_command = 0, ext_sync_in = 0;
    cycle_cmd_s cycle_cmd = '0;
    logic [1:0] sector_mode = 2'h0;
    phase_cfg_e phase_cfg = cfg_8f6c;
    phase_prog_s phase_prog [PHASES];
    force_timing_e group_timing [GROUPS];
    logic [PINS-1:0] force_data = '1, pin_mask = '0, seen_level;
    logic cycle_start_mark_r, shift_clock_r, active_range_r;
    logic cycle_error_r, test_halted_r;
    logic [PHASES-1:0] phase_out_r, phase_is_force_r;
    logic [3:0] last_compare_r;
    logic [2:0] pulse_mode_r;
    logic [PINS-1:0] force_drive_r, compare_strobe_r, program_sel_r;
    int fail_count = 0, check_count = 0, n, s, hi;
    logic prev;
    int t_ns[8] = '{48, 63, 100, 192, 16376, 16384, 16684, 20000};
    int t_md[8] = '{0, 0, 1, 3, 0, 0, 0, 1};
    int t_per[8] = '{6, 7, 12, 24, 2047, 2048, 2112, 2560};
    int t_sh[8] = '{1, 1, 2, 4, 1, 1, 1, 2};
    int e_ns[4] = '{40, 1048001, 80, 1048000};
    int e_md[4] = '{0, 0, 1, 0};
    logic [13:0] frc[4] = '{14'h1C0F, 14'h10FF, 14'h1CFF, 14'h004F};
    logic [3:0] lst[4] = '{4'h6, 4'hA, 4'h9, 4'h6};
    logic [2:0] pm[4] = '{3'h1, 3'h2, 3'h2, 3'h4};

    tester_cycle_phase_timing dut (.ref_clk, .rst, .cycle_cmd, .cycle_load,
        .sector_mode, .phase_cfg, .phase_prog, .group_timing, .force_data,
        .pin_mask, .select_program_phases, .restore_initial_phases,
        .initialise_command, .start_button, .ext_sync_in,
        .cycle_start_mark_r, .shift_clock_r, .phase_out_r,
        .phase_is_force_r, .last_compare_r, .force_drive_r,
        .compare_strobe_r, .program_sel_r, .pulse_mode_r, .active_range_r,
        .cycle_error_r, .test_halted_r);
    dut_pin_model model (.ref_clk, .cycle_start_mark(cycle_start_mark_r),
        .force_drive(force_drive_r), .seen_level);

    initial forever #12.5 ref_clk = ~ref_clk;

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic chk_n(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic load(input int ns, input logic ext, input int md);
        @(negedge ref_clk);
        cycle_cmd = '{ns: CYC_W'(ns), ext_sync: ext};
        sector_mode = 2'(md);
        cycle_load = 1;
        @(negedge ref_clk);
        cycle_load = 0;
        repeat (2) @(negedge ref_clk);
    endtask : load

    // Cycles and shift pulses from one mark to the next
    task automatic period(output int cyc, output int sh);
        int k;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (cycle_start_mark_r !== 1'b1 && k < 5000);
        cyc = 0;
        sh = 0;
        do begin
            @(negedge ref_clk);
            cyc++;
            if (shift_clock_r === 1'b1) sh++;
        end while (cycle_start_mark_r !== 1'b1 && cyc < 5000);
    endtask : period

    task automatic cmd(input logic sl, rs, ini, input logic [63:0] m);
        @(negedge ref_clk);
        {select_program_phases, restore_initial_phases} = {sl, rs};
        initialise_command = ini;
        pin_mask = m;
        @(negedge ref_clk);
        {select_program_phases, restore_initial_phases} = 2'h0;
        initialise_command = 0;
        @(negedge ref_clk);
    endtask : cmd

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        for (int i = 0; i < PHASES; i++) phase_prog[i] = '{16'h2, 16'h2};
        for (int i = 0; i < GROUPS; i++) group_timing[i] = non_return_timing;
        repeat (6) @(negedge ref_clk);
        rst = 0;
        chk("program_sel", 64'h0, program_sel_r);
        chk("last_compare", 64'h6, 64'(last_compare_r));
        for (int i = 0; i < 4; i++) begin
            phase_cfg = phase_cfg_e'(i);
            sector_mode = 2'(i);
            repeat (3) @(negedge ref_clk);
            chk("is_force", 64'(frc[i]), 64'(phase_is_force_r));
            chk("last_compare", 64'(lst[i]), 64'(last_compare_r));
            chk("pulse_mode", 64'(pm[i]), 64'(pulse_mode_r));
        end
        phase_cfg = cfg_8f6c;
        cmd(1, 0, 0, 64'h0000_0000_FFFF_0000);
        chk("program_sel", 64'h0000_0000_FFFF_0000, program_sel_r);
        cmd(1, 0, 0, 64'hFF);
        chk("program_sel", 64'h0000_0000_FFFF_00FF, program_sel_r);
        cmd(0, 1, 0, 64'h0000_0000_0F00_000F);
        chk("program_sel", 64'h0000_0000_F0FF_00F0, program_sel_r);
        cmd(1, 1, 0, 64'h0000_0000_0F00_0000);
        chk("program_sel", 64'h0000_0000_F0FF_00F0, program_sel_r);
        cmd(0, 0, 1, 64'h0);
        chk("program_sel", 64'h0, program_sel_r);
        cmd(1, 0, 0, '1);
        chk("program_sel", '1, program_sel_r);
        start_button = 1;
        repeat (6) @(negedge ref_clk);
        start_button = 0;
        chk("program_sel", 64'h0, program_sel_r);
        for (int i = 0; i < 8; i++) begin
            load(t_ns[i], 0, t_md[i]);
            chk("range", 64'(i > 4), 64'(active_range_r));
            period(n, s);
            chk_n("period", t_per[i], n);
            chk_n("shift_pulses", t_sh[i], s);
        end
        for (int i = 0; i < 4; i++) begin
            load(e_ns[i], 0, e_md[i]);
            chk("error", 64'(i < 3), 64'(cycle_error_r));
            chk("halted", 64'(i < 3), 64'(test_halted_r));
        end
        load(40, 0, 0);
        n = 0;
        repeat (20) @(negedge ref_clk) n += int'(cycle_start_mark_r === 1'b1);
        chk_n("marks_halted", 0, n);
        start_button = 1;
        repeat (6) @(negedge ref_clk);
        start_button = 0;
        chk("error", 64'h0, 64'(cycle_error_r));
        load(48, 1, 0);
        n = 0;
        repeat (30) @(negedge ref_clk) n += int'(cycle_start_mark_r === 1'b1);
        chk_n("marks_no_sync", 0, n);
        ext_sync_in = 1;
        n = 0;
        repeat (10) @(negedge ref_clk) n += int'(cycle_start_mark_r === 1'b1);
        ext_sync_in = 0;
        chk_n("marks_sync", 1, n);
        group_timing[0] = return_to_zero_timing;
        group_timing[1] = complement_return_timing;
        force_data = 64'hFFFF_FFFF_0000_FFFF;
        load(200, 0, 0);
        period(n, s);
        hi = 0;
        s = 0;
        prev = phase_out_r[10];
        repeat (25) begin
            @(negedge ref_clk);
            chk("zero_drive", 64'(prev), 64'(force_drive_r[0]));
            chk("compl_drive", 64'(!prev), 64'(force_drive_r[16]));
            chk("nrz_drive", 64'h1, 64'(force_drive_r[32]));
            hi += int'(phase_out_r[10] === 1'b1);
            s += int'(compare_strobe_r[0] === 1'b1);
            prev = phase_out_r[10];
        end
        chk_n("phase_width", 2, hi);
        chk_n("compare_width", 2, s);
        chk("dut_seen", 64'hFFFF, 64'(seen_level[47:32]));
        tally_and_finish();
    end
endmodule : test_tester_cycle_phase_timing
`default_nettype wire
